// [hw/ppio_pkg.sv]
package ppio_pkg;
  // ---------------------------------------------------------------
  // bus geometry: word registers, byte address is four times index
  // ---------------------------------------------------------------
  localparam int ADR_W = 6;
  localparam int DAT_W = 32;
  localparam int SEL_W = 4;
  localparam int IDX_LSB = 2;

  // ---------------------------------------------------------------
  // register indices
  // ---------------------------------------------------------------
  localparam logic [3:0] IDX_RESET = 4'h0;
  localparam logic [3:0] IDX_REQ = 4'h1;
  localparam logic [3:0] IDX_CTRL = 4'h2;
  localparam logic [3:0] IDX_DATA = 4'h3;
  localparam logic [3:0] IDX_READY = 4'h4;
  localparam logic [3:0] IDX_LINES = 4'h5;
  localparam logic [3:0] IDX_CFG = 4'h6;
  localparam logic [3:0] IDX_IEN = 4'h7;
  localparam logic [3:0] IDX_ISTAT = 4'h8;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CTRL_AUX0 = 0;
  localparam int CTRL_AUX1 = 1;
  localparam int CTRL_OKCHK = 2;
  localparam int LINES_AUX0 = 0;
  localparam int LINES_AUX1 = 1;
  localparam int LINES_EXT = 2;
  localparam int LINES_OK = 3;
  localparam int CFG_PULSE = 0;
  localparam int CFG_SRC_LSB = 1;
  localparam int EV_PERR = 0;
  localparam int EV_EXT = 4;
  localparam int EV_READY = 5;

  // ---------------------------------------------------------------
  // reset values and masks
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] IEN_RST = 8'h00;
  localparam logic [7:0] CTRL_MASK = 8'h07;
  localparam logic [7:0] CFG_MASK = 8'h07;
  localparam logic [7:0] IEN_MASK = 8'h30;
  localparam logic [7:0] ISTAT_MASK = 8'h31;
  localparam logic [15:0] DOUT_RST = 16'h0000;

  typedef enum logic [1:0] {
    SRC_ACK = 2'b00,
    SRC_START = 2'b01,
    SRC_READ = 2'b10
  } din_src_t;

  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_WAIT_BUSY = 2'b01,
    HS_WAIT_READY = 2'b10
  } hs_state_t;
endpackage : ppio_pkg

// [hw/hs_ctl.sv]
`timescale 1ns/1ps
module hs_ctl (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic abort,
  input wire logic pulse_mode,
  input wire logic flag_ready,
  output logic req,
  output logic ready,
  output logic ack
);
  import ppio_pkg::*;

  typedef struct packed {
    hs_state_t st;
    logic req;
    logic ready;
    logic ack;
  } hs_t;

  hs_t q;
  hs_t d;

  always_comb begin
    d = q;
    d.ack = 1'b0;
    case (q.st)
      HS_IDLE: begin
        if (start) begin
          d.st = HS_WAIT_BUSY;
          d.req = 1'b1;
        end
      end
      HS_WAIT_BUSY: begin
        if (!flag_ready) begin
          d.st = HS_WAIT_READY;
        end
      end
      HS_WAIT_READY: begin
        if (flag_ready) begin
          d.st = HS_IDLE;
          d.req = 1'b0;
          d.ack = 1'b1;
        end
      end
      default: begin
        d.st = HS_IDLE;
        d.req = 1'b0;
      end
    endcase
    if (abort) begin
      d.st = HS_IDLE;
      d.req = 1'b0;
      d.ack = 1'b0;
    end
    d.ready = !d.req && (pulse_mode || flag_ready);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{st: HS_IDLE, req: 1'b0, ready: 1'b0, ack: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign req = q.req;
  assign ready = q.ready;
  assign ack = q.ack;

  ready_full_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!$past(pulse_mode) && ready) |-> ($past(flag_ready) && !req))
    else $error("ready reported without flag ready or with request set");
  ready_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
    $past(pulse_mode) |-> (ready == !req))
    else $error("pulse mode ready does not follow request clear");
  req_start_a: assert property (@(posedge clk) disable iff (!rst_n)
    (start && q.st == HS_IDLE && !abort) |=> req ##1 (req || ack))
    else $error("transfer request not set by start");
  hs_ack_a: assert property (@(posedge clk) disable iff (!rst_n)
    ack |-> (!req && $past(req) && $past(flag_ready)))
    else $error("handshake ack without flag returning ready");
endmodule : hs_ctl

// [hw/evt_status.sv]
`timescale 1ns/1ps
module evt_status (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] set,
  input wire logic [7:0] clr,
  input wire logic flush,
  input wire logic [7:0] mask,
  output logic [7:0] status,
  output logic irq
);
  import ppio_pkg::*;

  typedef struct packed {
    logic [7:0] status;
    logic irq;
  } ev_t;

  ev_t q;
  ev_t d;

  // set beats the write-one clear, so a held level re-arms at once
  always_comb begin
    d = q;
    d.status = ((q.status & ~clr) | set) & ISTAT_MASK;
    if (flush) begin
      d.status = 8'h00;
    end
    d.irq = |(d.status & mask);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{status: 8'h00, irq: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign status = q.status;
  assign irq = q.irq;

  set_wins_a: assert property (@(posedge clk) disable iff (!rst_n)
    (set[EV_READY] && !flush) |=> status[EV_READY])
    else $error("level event lost against clear");
endmodule : evt_status

// [hw/parallel_port_handshake_lines.sv]
`timescale 1ns/1ps
module parallel_port_handshake_lines (
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [ppio_pkg::ADR_W-1:0] WB_ADR_I,
  input wire logic [ppio_pkg::SEL_W-1:0] WB_SEL_I,
  input wire logic [ppio_pkg::DAT_W-1:0] WB_DAT_I,
  output logic [ppio_pkg::DAT_W-1:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic [15:0] DATA_OUT,
  input wire logic [15:0] DATA_IN,
  output logic TRANSFER_REQUEST_LINE,
  input wire logic PERIPHERAL_FLAG_LINE,
  input wire logic PERIPHERAL_OK_LINE,
  input wire logic EXTERNAL_REQUEST_LINE_N,
  output logic AUX_OUT_FIRST_N,
  output logic AUX_OUT_SECOND_N,
  input wire logic AUX_IN_FIRST_N,
  input wire logic AUX_IN_SECOND_N,
  output logic IRQ
);
  import ppio_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic ack;
    logic [DAT_W-1:0] dat;
    logic [7:0] ctrl;
    logic [7:0] cfg;
    logic [7:0] ien;
    logic [15:0] dout;
    logic [15:0] din;
    logic aux0_n;
    logic aux1_n;
  } top_t;

  top_t q;
  top_t d;

  logic req_hit;
  logic wr;
  logic rd;
  logic [3:0] idx;
  logic lo_en;
  logic start;
  logic flush;
  logic [7:0] ev_set;
  logic [7:0] ev_clr;
  logic [7:0] istat;
  logic hs_req;
  logic hs_ready;
  logic hs_ack;
  logic irq_w;
  logic [7:0] lines;
  din_src_t src;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  // one answer per request: the cycle that shows ack is never a new hit
  assign req_hit = WB_CYC_I && WB_STB_I && !q.ack;
  assign wr = req_hit && WB_WE_I;
  assign rd = req_hit && !WB_WE_I;
  assign idx = WB_ADR_I[ADR_W-1:IDX_LSB];
  assign lo_en = WB_SEL_I[0];
  assign src = din_src_t'(q.cfg[CFG_SRC_LSB +: 2]);

  assign start = wr && lo_en && (idx == IDX_REQ) && (WB_DAT_I[7:0] != 8'h00);
  assign flush = wr && lo_en && (idx == IDX_RESET) && (WB_DAT_I[7:0] != 8'h00);

  // live pins, sampled at the request cycle and never held elsewhere
  assign lines = {4'h0, PERIPHERAL_OK_LINE, !EXTERNAL_REQUEST_LINE_N,
    !AUX_IN_SECOND_N, !AUX_IN_FIRST_N};

  // ---------------------------------------------------------------
  // events
  // ---------------------------------------------------------------
  always_comb begin
    ev_set = 8'h00;
    ev_set[EV_READY] = hs_ready;
    ev_set[EV_EXT] = !EXTERNAL_REQUEST_LINE_N;
    // the ok check is armed only by control bit 2
    ev_set[EV_PERR] = start && q.ctrl[CTRL_OKCHK] && !PERIPHERAL_OK_LINE;
    ev_clr = 8'h00;
    if (wr && lo_en && idx == IDX_ISTAT) begin
      ev_clr = WB_DAT_I[7:0] & ISTAT_MASK;
    end
  end

  hs_ctl u_hs (
    .clk(CORE_CLK),
    .rst_n(ARST_N),
    .start(start),
    .abort(flush),
    .pulse_mode(q.cfg[CFG_PULSE]),
    .flag_ready(PERIPHERAL_FLAG_LINE),
    .req(hs_req),
    .ready(hs_ready),
    .ack(hs_ack)
  );

  // peripheral error bit sits outside the mask, so it never interrupts
  evt_status u_ev (
    .clk(CORE_CLK),
    .rst_n(ARST_N),
    .set(ev_set),
    .clr(ev_clr),
    .flush(flush),
    .mask(q.ien & IEN_MASK),
    .status(istat),
    .irq(irq_w)
  );

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    d.ack = req_hit;
    d.dat = '0;
    if (rd) begin
      case (idx)
        IDX_REQ: d.dat[0] = hs_req;
        IDX_CTRL: d.dat[7:0] = q.ctrl;
        IDX_DATA: d.dat[15:0] = (src == SRC_READ) ? DATA_IN : q.din;
        IDX_READY: d.dat[0] = hs_ready;
        IDX_LINES: d.dat[7:0] = lines;
        IDX_CFG: d.dat[7:0] = q.cfg;
        IDX_IEN: d.dat[7:0] = q.ien;
        IDX_ISTAT: d.dat[7:0] = istat;
        default: d.dat = '0;
      endcase
    end
    if (wr && lo_en) begin
      case (idx)
        IDX_CTRL: begin
          d.ctrl = WB_DAT_I[7:0] & CTRL_MASK;
          d.aux0_n = !WB_DAT_I[CTRL_AUX0];
          d.aux1_n = !WB_DAT_I[CTRL_AUX1];
        end
        IDX_CFG: d.cfg = WB_DAT_I[7:0] & CFG_MASK;
        IDX_IEN: d.ien = WB_DAT_I[7:0] & IEN_MASK;
        default: d.cfg = q.cfg;
      endcase
    end
    // a byte-wide write still loads the whole word, unselected byte zero
    if (wr && idx == IDX_DATA && (WB_SEL_I[1:0] != 2'b00)) begin
      d.dout[7:0] = WB_SEL_I[0] ? WB_DAT_I[7:0] : 8'h00;
      d.dout[15:8] = WB_SEL_I[1] ? WB_DAT_I[15:8] : 8'h00;
    end
    // interface reset drops enables but leaves aux levels alone
    if (flush) begin
      d.ien = IEN_RST;
    end
    case (src)
      SRC_ACK: if (hs_ack) d.din = DATA_IN;
      SRC_START: if (start) d.din = DATA_IN;
      SRC_READ: if (rd && idx == IDX_DATA) d.din = DATA_IN;
      default: d.din = q.din;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      q <= '{ack: 1'b0, dat: '0, ctrl: CTRL_RST, cfg: CFG_RST, ien: IEN_RST,
        dout: DOUT_RST, din: 16'h0000, aux0_n: 1'b1, aux1_n: 1'b1};
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign WB_ACK_O = q.ack;
  assign WB_DAT_O = q.dat;
  assign DATA_OUT = q.dout;
  assign TRANSFER_REQUEST_LINE = hs_req;
  assign AUX_OUT_FIRST_N = q.aux0_n;
  assign AUX_OUT_SECOND_N = q.aux1_n;
  assign IRQ = irq_w;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  ready_event_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    (hs_ready && !flush) |=> istat[EV_READY] ##0
      (IRQ == $past(q.ien[EV_READY]) || istat[EV_EXT]))
    else $error("ready did not raise its event");
  ext_event_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    (!EXTERNAL_REQUEST_LINE_N && !flush) |=> istat[EV_EXT])
    else $error("external request did not raise its event");
  dout_byte_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    (wr && idx == IDX_DATA && WB_SEL_I[1:0] == 2'b01) |=>
      (DATA_OUT == {8'h00, $past(WB_DAT_I[7:0])}))
    else $error("byte data-out write left upper byte nonzero");
  din_ack_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    (src == SRC_ACK && hs_ack) |=> (q.din == $past(DATA_IN)))
    else $error("data-in not captured on handshake ack");
  aux_drive_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    (wr && lo_en && idx == IDX_CTRL) |=>
      (AUX_OUT_FIRST_N == !$past(WB_DAT_I[0]) && AUX_OUT_SECOND_N == !$past(WB_DAT_I[1])))
    else $error("aux outputs do not follow control bits");
  aux_hold_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    !(wr && lo_en && idx == IDX_CTRL) |=> ($stable(AUX_OUT_FIRST_N) && $stable(AUX_OUT_SECOND_N)))
    else $error("aux output moved without a control write");
  lines_read_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    (rd && idx == IDX_LINES) |=> (WB_ACK_O && WB_DAT_O[7:4] == 4'h0 &&
      WB_DAT_O[0] == !$past(AUX_IN_FIRST_N) && WB_DAT_O[3] == $past(PERIPHERAL_OK_LINE)))
    else $error("line status read wrong");
  perr_flag_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    (start && q.ctrl[CTRL_OKCHK] && !PERIPHERAL_OK_LINE && !flush) |=> istat[EV_PERR])
    else $error("peripheral error not flagged");
  no_check_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    (!q.ctrl[CTRL_OKCHK] && !istat[EV_PERR]) |=> !istat[EV_PERR])
    else $error("peripheral error flagged with check off");
  ready_read_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    (rd && idx == IDX_READY) |=> (WB_DAT_O[0] == $past(hs_ready)))
    else $error("ready register does not show ready");
  wb_ack_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held past one cycle");

  // ---------------------------------------------------------------
  // bus checks
  // ---------------------------------------------------------------
  ack_answer_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    req_hit |=> WB_ACK_O)
    else $error("request not answered in one cycle");

  idle_data_zero_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    !WB_ACK_O |-> (WB_DAT_O == '0))
    else $error("read data not zero outside ack");

  unmapped_read_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    (rd && idx > IDX_ISTAT) |=> (WB_DAT_O == '0))
    else $error("unmapped read not zero");

  ctrl_read_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    (rd && idx == IDX_CTRL) |=> (WB_DAT_O[7:0] == $past(q.ctrl)))
    else $error("control read wrong");

  // ---------------------------------------------------------------
  // handshake checks
  // ---------------------------------------------------------------
  req_out_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    (start && !flush && !TRANSFER_REQUEST_LINE) |=> TRANSFER_REQUEST_LINE)
    else $error("start did not raise the request line");

  req_flush_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    flush |=> !TRANSFER_REQUEST_LINE)
    else $error("interface reset left the request set");

  ready_busy_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    TRANSFER_REQUEST_LINE |-> !hs_ready)
    else $error("ready while request set");

  ready_full_top_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    (!$past(q.cfg[CFG_PULSE]) && hs_ready) |->
      ($past(PERIPHERAL_FLAG_LINE) && !TRANSFER_REQUEST_LINE))
    else $error("full mode ready without flag ready");

  ready_pulse_top_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    ($past(q.cfg[CFG_PULSE]) && !TRANSFER_REQUEST_LINE) |-> hs_ready)
    else $error("pulse mode not ready with request clear");

  req_hold_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    (TRANSFER_REQUEST_LINE && !flush && !PERIPHERAL_FLAG_LINE) |=> TRANSFER_REQUEST_LINE)
    else $error("request dropped while flag busy");

  req_clear_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    $fell(TRANSFER_REQUEST_LINE) |-> ($past(flush) || $past(PERIPHERAL_FLAG_LINE)))
    else $error("request cleared without flag ready");

  // ---------------------------------------------------------------
  // data-in and line checks
  // ---------------------------------------------------------------
  din_start_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    (src == SRC_START && start) |=> (q.din == $past(DATA_IN)))
    else $error("data-in not captured at start");

  din_read_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    (src == SRC_READ && rd && idx == IDX_DATA) |=> (WB_DAT_O[15:0] == $past(DATA_IN)))
    else $error("data-in read not live");

  din_keep_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    (src == SRC_ACK && !hs_ack) |=> $stable(q.din))
    else $error("data-in moved without handshake ack");

  lines_zero_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    (rd && idx == IDX_LINES) |=> (WB_DAT_O[DAT_W-1:4] == '0))
    else $error("line status upper bits not zero");

  lines_aux2_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    (rd && idx == IDX_LINES) |=> (WB_DAT_O[1] == !$past(AUX_IN_SECOND_N)))
    else $error("second aux input read wrong");

  lines_ext_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    (rd && idx == IDX_LINES) |=> (WB_DAT_O[2] == !$past(EXTERNAL_REQUEST_LINE_N)))
    else $error("external line read wrong");

  aux_level_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    (AUX_OUT_FIRST_N == !q.ctrl[CTRL_AUX0]) && (AUX_OUT_SECOND_N == !q.ctrl[CTRL_AUX1]))
    else $error("aux level differs from control bit");

  // ---------------------------------------------------------------
  // event checks
  // ---------------------------------------------------------------
  irq_level_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    IRQ == |(istat & $past(q.ien) & IEN_MASK))
    else $error("interrupt line not the masked status");

  perr_no_irq_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    (istat == 8'h01) |-> !IRQ)
    else $error("peripheral error raised the interrupt");

  perr_ok_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    (start && PERIPHERAL_OK_LINE && !istat[EV_PERR]) |=> !istat[EV_PERR])
    else $error("peripheral error with ok line true");

  flush_clear_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    flush |=> (istat == 8'h00))
    else $error("interface reset left event status");

  ext_irq_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    (!EXTERNAL_REQUEST_LINE_N && q.ien[EV_EXT] && !flush) |=> IRQ)
    else $error("enabled external request did not interrupt");

  ready_irq_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    (hs_ready && q.ien[EV_READY] && !flush) |=> IRQ)
    else $error("enabled ready did not interrupt");
endmodule : parallel_port_handshake_lines

// [bench/periph_model.sv]
`timescale 1ns/1ps
// ---------------------------------------------------------------
// peripheral on the handshake lines
// ---------------------------------------------------------------
module periph_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req,
  input wire logic hold,
  input wire logic [3:0] dly,
  output logic flag
);
  int cnt;

  // the flag answers a request busy after dly cycles, ready after 2*dly
  // hold keeps the flag busy only while no request is pending
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      flag <= 1'b1;
    end else if (!req) begin
      cnt <= 0;
      flag <= !hold;
    end else begin
      if (cnt <= 2 * dly) begin
        cnt <= cnt + 1;
      end
      if (cnt == dly) begin
        flag <= 1'b0;
      end
      if (cnt == 2 * dly) begin
        flag <= 1'b1;
      end
    end
  end
endmodule : periph_model

// [bench/parallel_port_handshake_lines_tb.sv]
`timescale 1ns/1ps
module parallel_port_handshake_lines_tb;
  import ppio_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [ADR_W-1:0] adr = '0;
  logic [SEL_W-1:0] sel = '0;
  logic [DAT_W-1:0] wdat = '0;
  logic [DAT_W-1:0] rdat;
  logic ack, req, flag, irq, aux1_n, aux2_n;
  logic [15:0] dout;
  logic [15:0] din = 16'h0000;
  logic ok = 1'b1;
  logic ext_n = 1'b1;
  logic in1_n = 1'b1;
  logic in2_n = 1'b1;
  logic hold = 1'b0;
  logic [3:0] dly = 4'ha;
  logic [31:0] q;
  int error_cnt = 0;
  int n_checks = 0;

  parallel_port_handshake_lines dut_u (
    .CORE_CLK(clk), .ARST_N(arst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .DATA_OUT(dout), .DATA_IN(din), .TRANSFER_REQUEST_LINE(req),
    .PERIPHERAL_FLAG_LINE(flag), .PERIPHERAL_OK_LINE(ok), .EXTERNAL_REQUEST_LINE_N(ext_n),
    .AUX_OUT_FIRST_N(aux1_n), .AUX_OUT_SECOND_N(aux2_n), .AUX_IN_FIRST_N(in1_n),
    .AUX_IN_SECOND_N(in2_n), .IRQ(irq)
  );
  periph_model peer_u (.clk(clk), .rst_n(arst_n), .req(req), .hold(hold), .dly(dly),
    .flag(flag));

  initial begin
    forever #25 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task final_report;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report

  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  // one classic cycle; ack and read data are taken at the same edge
  task wb(input logic w, input logic [3:0] i, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    sel <= s;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    chk({31'h0, ack}, 32'h1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task wr(input logic [3:0] i, input logic [31:0] d);
    wb(1'b1, i, d, 4'hf);
  endtask : wr

  task rd(input logic [3:0] i);
    wb(1'b0, i, 32'h0, 4'hf);
  endtask : rd

  task wait_req_low;
    int n;
    n = 0;
    while (req !== 1'b0 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, req}, 32'h0);
    repeat (2) @(posedge clk);
  endtask : wait_req_low

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_reset;
    chk({14'h0, aux2_n, aux1_n, dout}, 32'h0003_0000);
    chk({30'h0, req, irq}, 32'h0);
    rd(IDX_READY);
    chk(q, 32'h1);
  endtask : t_reset

  task t_aux;
    for (int v = 0; v < 4; v++) begin
      wr(IDX_CTRL, v);
      rd(IDX_READY);
      chk({30'h0, aux2_n, aux1_n}, 32'(3 - v));
    end
    wr(IDX_RESET, 32'h1);
    repeat (3) @(posedge clk);
    chk({30'h0, aux2_n, aux1_n}, 32'h0);
    wr(IDX_CTRL, 32'h0);
  endtask : t_aux

  task t_lines;
    for (int v = 0; v < 16; v++) begin
      in1_n <= !v[0];
      in2_n <= !v[1];
      ext_n <= !v[2];
      ok <= v[3];
      rd(IDX_LINES);
      chk(q, v);
    end
    in1_n <= 1'b1;
    in2_n <= 1'b1;
    ext_n <= 1'b1;
    ok <= 1'b1;
  endtask : t_lines

  task t_dout;
    wr(IDX_DATA, 32'h1234_abcd);
    rd(IDX_READY);
    chk({16'h0, dout}, 32'h0000_abcd);
    wb(1'b1, IDX_DATA, 32'h0000_c35a, 4'h1);
    rd(IDX_READY);
    chk({16'h0, dout}, 32'h0000_005a);
  endtask : t_dout

  // slow peer: the interrupt is cleared while busy, then comes back on ready
  task t_ready_irq;
    din <= 16'hc3a5;
    wr(IDX_IEN, 32'h20);
    wr(IDX_REQ, 32'h2);
    rd(IDX_READY);
    chk(q, 32'h0);
    chk({31'h0, req}, 32'h1);
    wr(IDX_ISTAT, 32'h20);
    rd(IDX_ISTAT);
    chk(q & 32'h20, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wait_req_low();
    din <= 16'h1111;
    rd(IDX_DATA);
    chk(q, 32'h0000_c3a5);
    chk({31'h0, irq}, 32'h1);
    wr(IDX_IEN, 32'h0);
    rd(IDX_READY);
    chk({31'h0, irq}, 32'h0);
  endtask : t_ready_irq

  task t_pulse;
    hold <= 1'b1;
    // flag falls one edge later, ready one more
    repeat (2) @(posedge clk);
    rd(IDX_READY);
    chk(q, 32'h0);
    wr(IDX_CFG, 32'h1);
    rd(IDX_READY);
    chk(q, 32'h1);
    wr(IDX_REQ, 32'h1);
    rd(IDX_READY);
    chk(q, 32'h0);
    hold <= 1'b0;
    wait_req_low();
    rd(IDX_READY);
    chk(q, 32'h1);
    wr(IDX_CFG, 32'h0);
  endtask : t_pulse

  // prompt peer; the error flag must never reach the interrupt line
  task t_okchk;
    dly <= 4'h1;
    ok <= 1'b0;
    wr(IDX_IEN, 32'h10);
    wr(IDX_ISTAT, 32'h31);
    wr(IDX_REQ, 32'h1);
    wait_req_low();
    rd(IDX_ISTAT);
    chk(q & 32'h1, 32'h0);
    wr(IDX_CTRL, 32'h4);
    wr(IDX_REQ, 32'h1);
    wait_req_low();
    rd(IDX_ISTAT);
    chk(q & 32'h1, 32'h1);
    chk({31'h0, irq}, 32'h0);
    ok <= 1'b1;
    wr(IDX_CTRL, 32'h0);
  endtask : t_okchk

  // capture at the start write, then live lines on a read
  task t_din_src;
    wr(IDX_CFG, 32'h2);
    din <= 16'h5a5a;
    wr(IDX_REQ, 32'h1);
    din <= 16'h0f0f;
    wait_req_low();
    rd(IDX_DATA);
    chk(q, 32'h0000_5a5a);
    wr(IDX_CFG, 32'h4);
    din <= 16'h9696;
    rd(IDX_DATA);
    chk(q, 32'h0000_9696);
    wr(IDX_CFG, 32'h0);
  endtask : t_din_src

  task t_ext;
    ext_n <= 1'b0;
    rd(IDX_ISTAT);
    chk(q & 32'h10, 32'h10);
    chk({31'h0, irq}, 32'h1);
    wr(IDX_ISTAT, 32'h10);
    rd(IDX_ISTAT);
    chk(q & 32'h10, 32'h10);
    ext_n <= 1'b1;
    wr(IDX_ISTAT, 32'h10);
    rd(IDX_ISTAT);
    chk(q & 32'h10, 32'h0);
    chk({31'h0, irq}, 32'h0);
  endtask : t_ext

  task t_unmapped;
    wr(4'hf, 32'hff);
    rd(4'hf);
    chk(q, 32'h0);
    rd(IDX_CTRL);
    chk(q, 32'h0);
  endtask : t_unmapped

  // ---------------------------------------------------------------
  // sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_aux();
    t_lines();
    t_dout();
    t_ready_irq();
    t_pulse();
    t_okchk();
    t_din_src();
    t_ext();
    t_unmapped();
    final_report();
  end

  // the run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    final_report();
  end
endmodule : parallel_port_handshake_lines_tb
